//--- mac_shift_round_subtract_ops_test.sv
// bench for the accumulator unit: bus register tasks and instruction runs
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
  failures++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
  end end
module mac_shift_round_subtract_ops_test;
  import msr_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, insn_code, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, store_mode, pointer_mode;
  logic insn_valid, store_valid, store_to_memory, index_step_valid;
  logic pointer_step_valid, saturation_mode_bit;
  logic [15:0] operand_a, operand_b, store_data, sum_high_word, sum_low_word;
  logic [7:0] store_target, sum_extension_byte;
  logic [3:0] index_pointer, pointer_sel;
  logic [6:0] flags;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  msr_unit msr_unit_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .insn_valid,
    .insn_code, .operand_a, .operand_b, .store_valid, .store_data,
    .store_to_memory, .store_target, .store_mode, .index_step_valid,
    .index_pointer, .pointer_step_valid, .pointer_sel, .pointer_mode,
    .flags, .sum_extension_byte, .sum_high_word, .sum_low_word,
    .saturation_mode_bit, .irq
  );
  msr_cpu_model msr_cpu_model_inst (
    .hclk, .insn_valid, .insn_code, .operand_a, .operand_b
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // single word transfer; read data taken at the data-phase edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h0);
    `CHK("register", ex, rd)
  endtask
  task automatic op(input logic [31:0] c, input logic [15:0] a, b,
                    input logic [39:0] es, input logic [6:0] ef);
    msr_cpu_model_inst.issue(c, a, b);
    #1;
    `CHK("sum", es, ({sum_extension_byte, sum_high_word, sum_low_word}))
    `CHK("flags", ef, flags)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // ceiling is far above the hundred or so cycles the sequence needs
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(OFF_CTRL, 32'h0);
    rdchk(OFF_IRQ_MASK, 32'h0);
    rdchk(OFF_FLAGS, 32'h0);
    rdchk(8'h40, 32'h0);
    `CHK("hresp", 1'b0, hresp)
    op(32'h000A_00A3, 16'h0001, 16'h0, 40'hFF_FFFF_FFFF, 7'h05);
    op(32'h004A_0083, 16'hFFFF, 16'hFFFF, 40'h1, 7'h00);
    op(32'h008A_00A3, 16'hFFFF, 16'h0, 40'h8000, 7'h00);
    op(32'h1082_00A3, 16'h0, 16'h0, 40'h00_8000_0000, 7'h10);
    op(32'h0982_00A3, 16'h0, 16'h0, 40'h0, 7'h06);
    op(32'h000A_00A3, 16'h0001, 16'h8000, 40'h7FFF_FFFF, 7'h04);
    op(32'h0882_00A3, 16'h0, 16'h0, 40'h7F_FFFF_FF00, 7'h10);
    bus(1'b1, OFF_IRQ_MASK, 32'h1);
    op(32'h00B2_00A3, 16'h0, 16'h0, 40'h80_0000_0000, 7'h59);
    @(posedge hclk);
    #1;
    `CHK("irq", 1'b1, irq)
    rdchk(OFF_IRQ_STATUS, 32'h1);
    @(posedge hclk);
    #1;
    `CHK("irq", 1'b0, irq)
    op(32'h0092_00A3, 16'h0, 16'h0, 40'h80_0000_0000, 7'h19);
    op(32'h1192_00A3, 16'h0, 16'h0, 40'h80_0000_0000, 7'h19);
    op(32'h009A_00A3, 16'hFFF4, 16'h0, 40'h08_0000_0000, 7'h18);
    bus(1'b1, OFF_CTRL, 32'h1);
    rdchk(OFF_CTRL, 32'h1);
    op(32'h000A_00A3, 16'h0, 16'h0, 40'h7FFF_FFFF, 7'h38);
    rdchk(OFF_IRQ_STATUS, 32'h6);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, OFF_FLAGS, 32'h0);
    rdchk(OFF_FLAGS, 32'h38);
    op(32'h0008_05C3, 16'h0, 16'h0, 40'h7FFF_FFFF, 7'h38);
    `CHK("store_data", 16'h7FFF, store_data)
    `CHK("store_target", 8'h05, store_target)
    `CHK("store_valid", 1'b1, store_valid)
    `CHK("store_to_memory", 1'b0, store_to_memory)
    op(32'h0000_01C3, 16'h0, 16'h0, 40'h7FFF_FFFF, 7'h38);
    `CHK("store_data", 16'hFFFF, store_data)
    op(32'h0010_03C3, 16'h0, 16'h0, 40'h7FFF_FFFF, 7'h38);
    `CHK("store_data", 16'h0000, store_data)
    op(32'h0018_02C3, 16'h0, 16'h0, 40'h7FFF_FFFF, 7'h38);
    `CHK("store_data", 16'h0001, store_data)
    op(32'h0520_07B3, 16'h0, 16'h0, 40'h7FFF_FFFF, 7'h38);
    `CHK("store_data", 16'h0038, store_data)
    `CHK("store_to_memory", 1'b1, store_to_memory)
    `CHK("store_mode", 3'h5, store_mode)
    op(32'h025A_3193, 16'h0, 16'h0, 40'h7FFF_FFFF, 7'h38);
    `CHK("index_pointer", 4'h3, index_pointer)
    `CHK("pointer_sel", 4'h1, pointer_sel)
    `CHK("pointer_mode", 3'h2, pointer_mode)
    `CHK("index_step_valid", 1'b1, index_step_valid)
    `CHK("pointer_step_valid", 1'b1, pointer_step_valid)
    op(32'h015A_1793, 16'h0, 16'h0, 40'h7FFF_FFFF, 7'h38);
    `CHK("index_step_valid", 1'b0, index_step_valid)
    `CHK("pointer_step_valid", 1'b1, pointer_step_valid)
    `CHK("pointer_sel", 4'h7, pointer_sel)
    op(32'h015A_5093, 16'h0, 16'h0, 40'h7FFF_FFFF, 7'h38);
    `CHK("index_step_valid", 1'b1, index_step_valid)
    `CHK("pointer_step_valid", 1'b0, pointer_step_valid)
    `CHK("index_pointer", 4'h5, index_pointer)
    op(32'h0982_00A3, 16'h0, 16'h0, 40'hFF_FFFF_FE00, 7'h29);
    op(32'h0082_00A3, 16'h0, 16'h0, 40'hFF_FFFF_FE00, 7'h2D);
    complete_run();
  end
endmodule

//--- msr_cpu_model.sv
// host core model that issues one coprocessor instruction per call
`timescale 1ns/1ps
module msr_cpu_model (
  input wire logic hclk,
  output logic insn_valid,
  output logic [31:0] insn_code,
  output logic [15:0] operand_a,
  output logic [15:0] operand_b
);
  initial begin
    insn_valid = 1'b0;
    insn_code = 32'h0;
    operand_a = 16'h0;
    operand_b = 16'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // register-form shifts carry their count in the low nibble of operand_a
  task automatic issue(input logic [31:0] c, input logic [15:0] a, b);
    @(posedge hclk);
    insn_valid <= 1'b1;
    insn_code <= c;
    operand_a <= a;
    operand_b <= b;
    @(posedge hclk);
    insn_valid <= 1'b0;
    // released code and operands flip so nothing can lean on stale values
    insn_code <= ~c;
    operand_a <= ~a;
    operand_b <= ~b;
  endtask
endmodule

//--- msr_pkg.sv
// constants, encodings and register map of the accumulator shift/round/subtract unit
package msr_pkg;

  localparam int SUM_W = 40;
  localparam int WORD_W = 16;
  localparam int EXT_W = 8;
  localparam int FLAG_W = 7;
  localparam int IRQ_W = 3;

  // first instruction byte: operand addressing class
  localparam logic [7:0] CLASS_REG = 8'hA3;
  localparam logic [7:0] CLASS_IND = 8'h83;
  localparam logic [7:0] CLASS_IDX = 8'h93;
  localparam logic [7:0] CLASS_STORE_REG = 8'hC3;
  localparam logic [7:0] CLASS_STORE_MEM = 8'hB3;

  // third instruction byte: operation
  localparam logic [7:0] SUB_NOP = 8'h5A;
  localparam logic [7:0] SUB_RND = 8'hB2;
  localparam logic [7:0] SUB_SHL_IMM = 8'h82;
  localparam logic [7:0] SUB_SHL_REG = 8'h8A;
  localparam logic [7:0] SUB_SHR_IMM = 8'h92;
  localparam logic [7:0] SUB_SHR_REG = 8'h9A;
  localparam logic [7:0] SUB_SUB = 8'h0A;
  localparam logic [7:0] SUB_SUB2 = 8'h4A;

  localparam logic [5:0] SHIFT_MAX = 6'h10;
  localparam logic [39:0] ROUND_CONST = 40'h00_0000_8000;
  localparam logic [39:0] SAT_POS = 40'h00_7FFF_FFFF;
  localparam logic [39:0] SAT_NEG = 40'hFF_8000_0000;

  // store source select codes
  localparam logic [4:0] SEL_LOW = 5'h00;
  localparam logic [4:0] SEL_HIGH = 5'h01;
  localparam logic [4:0] SEL_EXT = 5'h02;
  localparam logic [4:0] SEL_CTRL = 5'h03;
  localparam logic [4:0] SEL_FLAGS = 5'h04;

  // flag bit positions
  localparam int F_NEG = 0;
  localparam int F_ZERO = 1;
  localparam int F_CARRY = 2;
  localparam int F_STICKY = 3;
  localparam int F_EXT = 4;
  localparam int F_SATL = 5;
  localparam int F_OVF = 6;

  // interrupt event bit positions
  localparam int E_OVF = 0;
  localparam int E_SAT = 1;
  localparam int E_BADCNT = 2;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_LOW = 8'h08;
  localparam logic [7:0] OFF_HIGH = 8'h0C;
  localparam logic [7:0] OFF_EXT = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [7:0] NOP_ONE_PTR = 8'h10;

endpackage

//--- msr_unit.sv
// accumulator shift, round, subtract, store and pointer-nop unit with AHB-Lite registers
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module msr_unit
  import msr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // instruction port from the cpu core
  input wire logic insn_valid,
  input wire logic [31:0] insn_code,
  input wire logic [15:0] operand_a,
  input wire logic [15:0] operand_b,
  // store result
  output logic store_valid,
  output logic [15:0] store_data,
  output logic store_to_memory,
  output logic [7:0] store_target,
  output logic [2:0] store_mode,
  // pointer step requests of the nop
  output logic index_step_valid,
  output logic [3:0] index_pointer,
  output logic pointer_step_valid,
  output logic [3:0] pointer_sel,
  output logic [2:0] pointer_mode,
  // state
  output logic [FLAG_W-1:0] flags,
  output logic [EXT_W-1:0] sum_extension_byte,
  output logic [WORD_W-1:0] sum_high_word,
  output logic [WORD_W-1:0] sum_low_word,
  output logic saturation_mode_bit,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // instruction decode

  wire [7:0] op_class = insn_code[7:0];
  wire [7:0] op_mod = insn_code[15:8];
  wire [7:0] op_sub = insn_code[23:16];
  wire [7:0] op_tail = insn_code[31:24];
  // pointer and mode fields shared by the nop and the store
  wire [3:0] index_field = op_mod[7:4];
  wire [3:0] reg_field = op_mod[3:0];
  wire [2:0] tail_mode = op_tail[2:0];

  wire cls_reg = (op_class == CLASS_REG);
  wire cls_ind = (op_class == CLASS_IND);
  wire cls_idx = (op_class == CLASS_IDX);
  wire cls_arith = cls_reg | cls_ind | cls_idx;

  wire is_nop = insn_valid & cls_idx & (op_sub == SUB_NOP);
  wire is_rnd = insn_valid & cls_reg & (op_sub == SUB_RND);
  wire shl_imm = cls_reg & (op_sub == SUB_SHL_IMM);
  wire shl_reg = (cls_reg | cls_ind) & (op_sub == SUB_SHL_REG);
  wire shr_imm = cls_reg & (op_sub == SUB_SHR_IMM);
  wire shr_reg = (cls_reg | cls_ind) & (op_sub == SUB_SHR_REG);
  wire is_sub = insn_valid & cls_arith & (op_sub == SUB_SUB);
  wire is_sub2 = insn_valid & cls_arith & (op_sub == SUB_SUB2);
  wire store_reg = insn_valid & (op_class == CLASS_STORE_REG);
  wire store_mem = insn_valid & (op_class == CLASS_STORE_MEM);
  // store only reads the sum, flags and mode bit, so it never writes sum or flags back
  wire is_store = store_reg | store_mem;

  // immediate 0..16 or register nibble 0..15
  wire imm_form = shl_imm | shr_imm;
  wire [5:0] shift_count = imm_form ? {1'b0, op_tail[4:0]}
                                    : {2'b00, operand_a[3:0]};
  wire count_ok = (shift_count <= SHIFT_MAX);
  wire any_shift = insn_valid & (shl_imm | shl_reg | shr_imm | shr_reg);
  // an illegal count leaves sum and flags alone and raises an event
  wire bad_count = any_shift & ~count_ok;
  wire is_shl = insn_valid & (shl_imm | shl_reg) & count_ok;
  wire is_shr = insn_valid & (shr_imm | shr_reg) & count_ok;

  ////////////////////////////////////////////////////////////////////////////
  // datapath

  wire [SUM_W-1:0] acc = {sum_extension_byte, sum_high_word, sum_low_word};
  // one guard bit lets the subtract see an underflow past bit 39
  wire [SUM_W:0] acc_x = {acc[SUM_W-1], acc};

  // round: plain unsigned add gives the carry, operand is positive
  wire [SUM_W:0] rnd_u = {1'b0, acc} + {1'b0, ROUND_CONST};
  wire rnd_carry = rnd_u[SUM_W];
  wire rnd_ovf = ~acc[SUM_W-1] & rnd_u[SUM_W-1];
  // round is the arithmetic right shift by zero with rounding: the shift
  // leaves the sum as it is, so only the add and the low-word clear remain
  wire [SUM_W-1:0] rnd_raw =
    {rnd_u[SUM_W-1:WORD_W], {WORD_W{1'b0}}};

  // subtract operand: high:low, sign-extended, optionally doubled
  wire [SUM_W:0] sub_opnd = is_sub2 ?
    {{EXT_W{operand_b[15]}}, operand_b, operand_a, 1'b0} :
    {{EXT_W+1{operand_b[15]}}, operand_b, operand_a};
  wire [SUM_W:0] sub_diff = acc_x - sub_opnd;
  wire sub_ovf = sub_diff[SUM_W] ^ sub_diff[SUM_W-1];
  // borrow is the unsigned compare of the two 40-bit patterns
  wire sub_borrow = (acc < sub_opnd[SUM_W-1:0]);

  // left shift: widened so the last bit out of bit 39 lands in bit 40
  wire [55:0] shl_wide = {16'h0000, acc} << shift_count;
  wire [SUM_W-1:0] shl_raw = shl_wide[SUM_W-1:0];
  wire shl_zero = (shift_count == 6'h00);
  wire shl_carry = shl_zero ? acc[SUM_W-1] : shl_wide[SUM_W];

  // right shift: zeros come in from the top
  wire [SUM_W-1:0] shr_raw = acc >> shift_count;

  // raw result, overflow and true sign of the arithmetic operations
  wire arith_op = is_rnd | is_sub | is_sub2;
  wire [SUM_W-1:0] raw = is_rnd ? rnd_raw :
                         (is_sub | is_sub2) ? sub_diff[SUM_W-1:0] :
                         is_shl ? shl_raw : shr_raw;
  wire raw_ovf = is_rnd ? rnd_ovf : ((is_sub | is_sub2) & sub_ovf);
  // left shift uses the 40-bit sign only, bits pushed past 39 are lost
  wire true_sign = is_shl ? shl_raw[SUM_W-1] :
                   is_rnd ? (rnd_ovf ? 1'b0 : rnd_u[SUM_W-1]) :
                   sub_diff[SUM_W];
  // extension use is judged before any clamp, so the flag still shows
  // a result that saturation pulled back into range
  wire ext_used = ~((&raw[SUM_W-1:31]) | ~(|raw[SUM_W-1:31]));

  // right shift never saturates whatever the mode bit says
  wire sat_allowed = (arith_op | is_shl) & saturation_mode_bit;
  wire sat_hit = sat_allowed & (ext_used | raw_ovf);
  // the clamp follows the true sign, not the wrapped bit 39, except for left shift, where true_sign is bit 39
  wire [SUM_W-1:0] sat_val = true_sign ? SAT_NEG : SAT_POS;
  wire [SUM_W-1:0] sat_res = sat_hit ? sat_val : raw;
  wire [SUM_W-1:0] result = is_rnd ?
    {sat_res[SUM_W-1:WORD_W], {WORD_W{1'b0}}} : sat_res;
  wire updates_sum = arith_op | is_shl | is_shr;

  // flags for every flag-affecting operation
  wire res_carry = is_rnd ? rnd_carry :
                   (is_sub | is_sub2) ? sub_borrow :
                   is_shl ? shl_carry : 1'b0;
  // nop, store and refused shifts leave every flag as it was
  logic [FLAG_W-1:0] next_flags;
  always_comb begin
    next_flags = flags;
    if (updates_sum) begin
      next_flags[F_OVF] = raw_ovf;
      next_flags[F_CARRY] = res_carry;
      next_flags[F_ZERO] = (result == {SUM_W{1'b0}});
      next_flags[F_NEG] = result[SUM_W-1];
      next_flags[F_EXT] = ext_used;
      next_flags[F_SATL] = flags[F_SATL] | sat_hit;
      next_flags[F_STICKY] = flags[F_STICKY] | raw_ovf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // store source select

  // codes past the flags word read as zero
  wire [4:0] store_sel = op_sub[7:3];
  logic [15:0] store_src;
  always_comb begin
    case (store_sel)
      SEL_LOW: store_src = sum_low_word;
      SEL_HIGH: store_src = sum_high_word;
      SEL_EXT: store_src = {8'h00, sum_extension_byte};
      SEL_CTRL: store_src = {15'h0000, saturation_mode_bit};
      SEL_FLAGS: store_src = {9'h000, flags};
      default: store_src = 16'h0000;
    endcase
  end

  // nop forms: index-only, register-only, otherwise both pointers
  wire nop_index_only = (reg_field == 4'h0) & (tail_mode == 3'h1);
  wire nop_reg_only = ~nop_index_only & (index_field == NOP_ONE_PTR[7:4]);

  ////////////////////////////////////////////////////////////////////////////
  // sum, flags, result ports
  // sum and flags move on the edge that takes the instruction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sum_extension_byte <= 8'h00;
      sum_high_word <= 16'h0000;
      sum_low_word <= 16'h0000;
    end else if (updates_sum) begin
      {sum_extension_byte, sum_high_word, sum_low_word} <= result;
    end
  end

  // nop and store never reach next_flags, so flags hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= 7'h00;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      store_valid <= 1'b0;
      store_data <= 16'h0000;
      store_to_memory <= 1'b0;
      store_target <= 8'h00;
      store_mode <= 3'h0;
    end else begin
      // one-cycle pulse; the data ports stand until the next store
      store_valid <= is_store;
      if (is_store) begin
        store_data <= store_src;
        store_to_memory <= store_mem;
        store_target <= op_mod;
        store_mode <= tail_mode;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      index_step_valid <= 1'b0;
      index_pointer <= 4'h0;
      pointer_step_valid <= 1'b0;
      pointer_sel <= 4'h0;
      pointer_mode <= 3'h0;
    end else begin
      // request pulses only: the core does the pointer arithmetic
      index_step_valid <= is_nop & ~nop_reg_only;
      pointer_step_valid <= is_nop & ~nop_index_only;
      if (is_nop) begin
        index_pointer <= index_field;
        pointer_sel <= reg_field;
        pointer_mode <= tail_mode;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states

  // hsize is not decoded: every register is one aligned word
  wire bus_take = hsel & htrans[1] & hready;
  wire [7:0] bus_off = haddr[7:0];
  wire rd_take = bus_take & ~hwrite;
  logic wr_pend;
  logic [7:0] wr_off;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;

  logic [31:0] rd_mux;
  always_comb begin
    case (bus_off)
      OFF_CTRL: rd_mux = {31'h0000_0000, saturation_mode_bit};
      OFF_FLAGS: rd_mux = {25'h000_0000, flags};
      OFF_LOW: rd_mux = {16'h0000, sum_low_word};
      OFF_HIGH: rd_mux = {16'h0000, sum_high_word};
      OFF_EXT: rd_mux = {24'h00_0000, sum_extension_byte};
      OFF_IRQ_STATUS: rd_mux = {29'h0000_0000, irq_status};
      OFF_IRQ_MASK: rd_mux = {29'h0000_0000, irq_mask};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_off <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend <= bus_take & hwrite;
      if (bus_take) begin
        wr_off <= bus_off;
      end
      if (rd_take) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY[0];
    end else begin
      // no wait states, so the slave is ready on every cycle
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY[0];
    end
  end

  // a write lands at the data-phase edge, where hwdata stands
  wire wr_ctrl = wr_pend & (wr_off == OFF_CTRL);
  wire wr_mask = wr_pend & (wr_off == OFF_IRQ_MASK);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      saturation_mode_bit <= 1'b0;
      irq_mask <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        saturation_mode_bit <= hwdata[0];
      end
      if (wr_mask) begin
        irq_mask <= hwdata[IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: sticky events, read clears, a new event wins over the clear

  wire [IRQ_W-1:0] events;
  assign events[E_OVF] = raw_ovf;
  assign events[E_SAT] = sat_hit;
  assign events[E_BADCNT] = bad_count;
  // the read clears every bit it returned; events of that cycle survive
  wire status_rd = rd_take & (bus_off == OFF_IRQ_STATUS);

  logic [IRQ_W-1:0] next_irq_status;
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
      assign next_irq_status[gi] = events[gi] |
                                   (irq_status[gi] & ~status_rd);
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
    end
  end

endmodule

//--- msr_unit_sva.sv
// assertions on the instruction side of the accumulator unit
`timescale 1ns/1ps
module msr_unit_sva
  import msr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic insn_valid,
  input wire logic [31:0] insn_code,
  input wire logic store_valid,
  input wire logic index_step_valid,
  input wire logic [FLAG_W-1:0] flags,
  input wire logic [EXT_W-1:0] sum_extension_byte,
  input wire logic [WORD_W-1:0] sum_high_word,
  input wire logic [WORD_W-1:0] sum_low_word,
  input wire logic saturation_mode_bit
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire [39:0] sum = {sum_extension_byte, sum_high_word, sum_low_word};
  wire [7:0] op_code = insn_code[23:16];
  wire [4:0] imm_cnt = insn_code[28:24];
  wire go_reg = insn_valid && insn_code[7:0] == CLASS_REG;
  wire is_nop = insn_valid && insn_code[7:0] == CLASS_IDX
    && op_code == SUB_NOP;
  wire is_store = insn_valid && (insn_code[7:0] == CLASS_STORE_REG
    || insn_code[7:0] == CLASS_STORE_MEM);
  wire shr_imm = go_reg && op_code == SUB_SHR_IMM && imm_cnt <= 5'h10;
  wire shl_imm = go_reg && op_code == SUB_SHL_IMM && imm_cnt <= 5'h10;
  wire is_rnd = go_reg && op_code == SUB_RND;
  ////////////////////////////////////////////////////////////////////////////
  property p_nop_keeps;
    is_nop |=> $stable(flags) && $stable(sum)
      && ($past(insn_code[15:12]) == 4'h1 || index_step_valid);
  endproperty
  a_nop_keeps: assert property (p_nop_keeps)
    else $error("pointer nop disturbed sum or flags");
  property p_store_keeps;
    is_store |=> store_valid && $stable(flags);
  endproperty
  a_store_keeps: assert property (p_store_keeps)
    else $error("store missing or flags changed");
  property p_rnd_low;
    is_rnd |=> sum_low_word == 16'h0000;
  endproperty
  a_rnd_low: assert property (p_rnd_low)
    else $error("round left low word set");
  property p_rnd_flags;
    is_rnd && !saturation_mode_bit |=>
      flags[F_OVF] == (!$past(sum[39]) && sum[39])
      && flags[F_CARRY] == ($past(sum[39]) && !sum[39]);
  endproperty
  a_rnd_flags: assert property (p_rnd_flags)
    else $error("round overflow or carry wrong");
  property p_sticky_hold;
    !$fell(flags[F_STICKY]) && (!flags[F_OVF] || flags[F_STICKY]);
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("sticky overflow lost or not set");
  property p_satl_hold;
    !$fell(flags[F_SATL]);
  endproperty
  a_satl_hold: assert property (p_satl_hold)
    else $error("saturation latch cleared");
  property p_shr_fill;
    shr_imm |=> sum == ($past(sum) >> $past(imm_cnt));
  endproperty
  a_shr_fill: assert property (p_shr_fill)
    else $error("right shift result wrong");
  property p_shr_flags;
    shr_imm |=> !flags[F_OVF] && !flags[F_CARRY]
      && flags[F_STICKY] == $past(flags[F_STICKY]);
  endproperty
  a_shr_flags: assert property (p_shr_flags)
    else $error("right shift flags wrong");
  property p_shl_flags;
    shl_imm |=> !flags[F_OVF] && $stable(flags[F_STICKY]);
  endproperty
  a_shl_flags: assert property (p_shl_flags)
    else $error("left shift overflow flags wrong");
  property p_sub_zn;
    go_reg && op_code == SUB_SUB |=> flags[F_ZERO] == (sum == 40'h0)
      && flags[F_NEG] == sum[39];
  endproperty
  a_sub_zn: assert property (p_sub_zn)
    else $error("zero or negative flag wrong");
  c_nop: cover property (is_nop);
  c_rnd: cover property (is_rnd);
  c_shl: cover property (shl_imm);
endmodule

bind msr_unit msr_unit_sva msr_unit_sva_inst (
  .hclk, .hresetn, .insn_valid, .insn_code, .store_valid,
  .index_step_valid, .flags, .sum_extension_byte, .sum_high_word,
  .sum_low_word, .saturation_mode_bit
);
